// *** logic/haptic_drive_setup_control.sv ***
/*
  Haptic drive setup and playback control: boot, parameters, levels, brake,
  wideband retune and pattern store gating.
  Assumes setup ports come from host logic on clk_sys; trigger_pin is async.
*/
`timescale 1ns/1ps
module haptic_drive_setup_control
  import haptic_pkg::*;
#(
  parameter int BOOT_LEN    = BOOT_CYCLES,
  parameter int STORE_DEPTH = 256
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Actuator setup
  input  wire logic        actuator_kind,
  input  wire logic [7:0]  rated_voltage_code,
  input  wire logic [7:0]  peak_limit_code,
  input  wire logic [4:0]  current_limit_code,
  input  wire logic [7:0]  scale_high_byte,
  input  wire logic [7:0]  scale_low_byte,
  input  wire logic [7:0]  resonance_period_high,
  input  wire logic [6:0]  resonance_period_low,
  input  wire logic        period_we,
  // Feature enables
  input  wire logic        tracking_en,
  input  wire logic        overdrive_en,
  input  wire logic        reverse_brake_en,
  input  wire logic        warm_wait_en,
  // Playback control
  input  wire logic [2:0]  playback_mode,
  input  wire logic        seq_start,
  input  wire logic        seq_done,
  input  wire logic        trigger_pin,
  input  wire logic [7:0]  amp_in,
  // Pattern store access
  input  wire logic        pattern_store_unlock,
  input  wire logic        store_we,
  input  wire logic [7:0]  store_addr,
  input  wire logic [7:0]  store_wdata,
  output logic [7:0]       store_rdata,
  output logic             store_dropped,
  output logic [7:0]       pattern_store_base_q,
  // Status and drive
  output play_state_t      state_q,
  output logic             drive_lra_q,
  output logic             drive_erm_q,
  output logic [7:0]       nominal_level_q,
  output logic [4:0]       current_limit_q,
  output logic [15:0]      voltage_to_current_scale_q,
  output logic [14:0]      resonance_period_q,
  output logic [14:0]      sense_period_q,
  output logic signed [8:0] drive_level_q,
  output logic             overdrive_active_q,
  output logic             reverse_phase_q,
  output logic             reverse_polarity_q,
  output logic             wideband_q,
  output logic             freq_update_q,
  output logic             feature_fault_q
);
  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------
  store_if     sbus ();            // Core to store carrier
  play_state_t state_d;            // Next playback state
  logic [31:0] boot_cnt_q;         // Boot interval counter
  logic [7:0]  brake_cnt_q;        // Brake length counter
  logic [7:0]  boost_cnt_q;        // Overdrive burst counter
  logic        boost_up_q;         // Burst direction
  logic signed [8:0] target_q;     // Last target level
  logic        kind_q;             // Latched actuator kind
  logic [7:0]  peak_q;             // Latched peak cap
  logic        pin_s;              // Synchronised trigger
  logic        pin_prev_q;         // Trigger history
  logic        start_prev_q;       // Start command history

  // -------------------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------------------
  wire booted     = (state_q != ST_BOOT);
  wire at_rest    = (state_q == ST_INACTIVE) || (state_q == ST_IDLE) || (state_q == ST_STANDBY);
  wire accel_ok   = overdrive_en && tracking_en;
  wire brake_ok   = reverse_brake_en && tracking_en;
  wire pin_edge   = pin_s ^ pin_prev_q;
  wire start_rise = seq_start && !start_prev_q;
  // Stop on the start command falling, not on its low level, so a
  // sequence launched by a pin edge with the command low keeps playing
  wire start_fall = !seq_start && start_prev_q;
  wire seq_mode   = (playback_mode == MODE_REG_SEQ) || (playback_mode == MODE_EDGE_SEQ);
  wire stream_mode = (playback_mode == MODE_OVERRIDE) || (playback_mode == MODE_PWM);
  wire start_req  = stream_mode
                 || ((playback_mode == MODE_REG_SEQ) && start_rise)
                 || ((playback_mode == MODE_EDGE_SEQ) && (start_rise || pin_edge));
  wire seq_stop   = seq_mode && (seq_done || start_fall
                 || ((playback_mode == MODE_EDGE_SEQ) && pin_edge));
  wire mode_off   = (playback_mode == MODE_INACTIVE);
  wire stop_req   = mode_off || seq_stop;
  wire boot_last  = (boot_cnt_q == 32'(BOOT_LEN - 1));
  wire brake_last = (brake_cnt_q == 8'(BRAKE_CYCLES - 1));
  wire play_state_t rest_state = warm_wait_en ? ST_STANDBY : ST_IDLE;
  // Amplitude: signed when overdrive and tracking both on, else unsigned
  wire signed [8:0] raw_level = accel_ok ? {amp_in[7], amp_in} : {1'b0, amp_in};
  wire signed [8:0] peak_pos  = {1'b0, peak_q};
  wire signed [8:0] peak_neg  = -peak_pos;
  // Clip to peak cap
  wire signed [8:0] capped    = (raw_level > peak_pos) ? peak_pos :
                                (raw_level < peak_neg) ? peak_neg : raw_level;
  wire level_change = (state_q == ST_DRIVE) && accel_ok && (capped != target_q);
  wire wideband_ok  = !tracking_en && !overdrive_en && !reverse_brake_en
                   && ((playback_mode == MODE_OVERRIDE) || seq_mode);
  wire [14:0] per_full = {resonance_period_high, resonance_period_low};

  // -------------------------------------------------------------------------
  // Submodules
  // -------------------------------------------------------------------------
  pin_sync u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (trigger_pin),
    .pin_s   (pin_s)
  );

  assign sbus.we    = store_we;
  assign sbus.addr  = store_addr;
  assign sbus.wdata = store_wdata;
  assign store_rdata   = sbus.rdata;
  assign store_dropped = sbus.drop;

  // Store accepts writes only when unlocked and booted
  pattern_store #(.DEPTH(STORE_DEPTH)) u_store (
    .clk_sys (clk_sys),
    .rst     (rst),
    .unlock  (pattern_store_unlock),
    .ready   (booted),
    .bus     (sbus.store)
  );

  // -------------------------------------------------------------------------
  // Playback state machine
  // -------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_BOOT: begin
        if (boot_last) state_d = ST_INACTIVE;
      end
      ST_INACTIVE, ST_IDLE, ST_STANDBY: begin
        if (mode_off) state_d = ST_INACTIVE;
        else if (start_req) state_d = ST_DRIVE;
      end
      ST_DRIVE: begin
        // Brake takes priority over a plain stop
        if (stop_req && brake_ok) state_d = ST_BRAKE;
        else if (mode_off) state_d = ST_INACTIVE;
        else if (seq_stop) state_d = rest_state;
      end
      ST_BRAKE: begin
        // Brake runs its full length, then picks the rest state
        if (brake_last) state_d = mode_off ? ST_INACTIVE : rest_state;
      end
      default: state_d = ST_INACTIVE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) state_q <= ST_BOOT;
    else state_q <= state_d;
  end

  // Boot and brake counters
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      boot_cnt_q  <= 32'h0000_0000;
      brake_cnt_q <= 8'h00;
    end else begin
      boot_cnt_q  <= booted ? boot_cnt_q : boot_cnt_q + 32'h0000_0001;
      brake_cnt_q <= (state_q == ST_BRAKE) ? brake_cnt_q + 8'h01 : 8'h00;
    end
  end

  // Trigger and start history
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_prev_q   <= 1'b0;
      start_prev_q <= 1'b0;
    end else begin
      pin_prev_q   <= pin_s;
      start_prev_q <= seq_start;
    end
  end

  // -------------------------------------------------------------------------
  // Actuator parameters, latched only after boot
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      kind_q                     <= KIND_LRA;
      peak_q                     <= 8'h00;
      nominal_level_q            <= 8'h00;
      current_limit_q            <= 5'h00;
      voltage_to_current_scale_q <= 16'h0000;
      drive_lra_q                <= 1'b0;
      drive_erm_q                <= 1'b0;
      feature_fault_q            <= 1'b0;
    end else if (booted) begin
      kind_q                     <= actuator_kind;
      drive_lra_q                <= (actuator_kind == KIND_LRA);
      drive_erm_q                <= (actuator_kind == KIND_ERM);
      peak_q                     <= peak_limit_code;
      nominal_level_q            <= rated_voltage_code;
      current_limit_q            <= current_limit_code;
      voltage_to_current_scale_q <= {scale_high_byte, scale_low_byte};
      feature_fault_q            <= (overdrive_en || reverse_brake_en) && !tracking_en;
    end
  end

  // Period, sensing rate and wideband retune
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      resonance_period_q <= 15'h0000;
      sense_period_q     <= MIN_SENSE_PER;
      wideband_q         <= 1'b0;
      freq_update_q      <= 1'b0;
    end else begin
      wideband_q    <= booted && wideband_ok;
      freq_update_q <= booted && period_we && wideband_ok
                    && (playback_mode == MODE_OVERRIDE) && (state_q == ST_DRIVE);
      if (booted && period_we) begin
        resonance_period_q <= per_full;
        // Rotating mass: period is sensing interval, floored at fastest rate
        sense_period_q <= (kind_q == KIND_ERM && per_full < MIN_SENSE_PER)
                        ? MIN_SENSE_PER : per_full;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Drive level, overdrive burst and reverse brake
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      target_q    <= 9'h000;
      boost_cnt_q <= 8'h00;
      boost_up_q  <= 1'b0;
    end else begin
      target_q <= (state_q == ST_DRIVE) ? capped : 9'h000;
      if (level_change) begin
        boost_cnt_q <= 8'(BOOST_CYCLES);
        boost_up_q  <= (capped > target_q);
      end else if (boost_cnt_q != 8'h00) begin
        boost_cnt_q <= boost_cnt_q - 8'h01;
      end
    end
  end

  // Output level and reverse flags
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drive_level_q      <= 9'h000;
      overdrive_active_q <= 1'b0;
      reverse_phase_q    <= 1'b0;
      reverse_polarity_q <= 1'b0;
    end else begin
      overdrive_active_q <= (state_q == ST_DRIVE) && (boost_cnt_q != 8'h00);
      reverse_phase_q    <= (state_q == ST_BRAKE) && (kind_q == KIND_LRA);
      reverse_polarity_q <= (state_q == ST_BRAKE) && (kind_q == KIND_ERM);
      if (state_q == ST_BRAKE) drive_level_q <= peak_pos;
      else if (state_q != ST_DRIVE) drive_level_q <= 9'h000;
      else if (boost_cnt_q != 8'h00) drive_level_q <= boost_up_q ? peak_pos : peak_neg;
      else drive_level_q <= capped;
    end
  end

  // Base pointer of the first snippet location
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) pattern_store_base_q <= 8'h00;
    else pattern_store_base_q <= STORE_BASE;
  end

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Boot holds its full length, then rests inactive
  a_boot_exit: assert property (state_q == ST_BOOT && boot_last |=> state_q == ST_INACTIVE)
    else $error("boot did not end in inactive");
  a_boot_hold: assert property (state_q == ST_BOOT && !boot_last |=> state_q == ST_BOOT)
    else $error("boot ended early");
  a_boot_quiet: assert property (state_q == ST_BOOT |-> drive_level_q == 9'h000 && !freq_update_q)
    else $error("activity during boot");

  // Setup decode and cap
  a_kind_decode: assert property (booted && actuator_kind == KIND_ERM |=> drive_erm_q && !drive_lra_q)
    else $error("kind decode wrong");
  a_peak_cap: assert property (drive_level_q <= peak_pos && drive_level_q >= peak_neg)
    else $error("level beyond peak cap");

  // Parts join into full values
  a_scale_join: assert property (booted |=> voltage_to_current_scale_q
    == 16'({$past(scale_high_byte), 8'h00}) + 16'($past(scale_low_byte)))
    else $error("scale not joined");
  a_period_split: assert property (booted && period_we |=> resonance_period_q
    == 15'($past(resonance_period_high)) * 15'h0080 + 15'($past(resonance_period_low)))
    else $error("period not joined");
  a_sense_floor: assert property (kind_q == KIND_ERM && booted && period_we
    |=> sense_period_q >= MIN_SENSE_PER)
    else $error("sense rate above limit");

  // Levels and brake
  a_unsigned_data: assert property (state_q == ST_DRIVE && !accel_ok && boost_cnt_q == 8'h00
    |=> drive_level_q >= 0)
    else $error("unsigned data went negative");
  a_brake_reverse: assert property (state_q == ST_BRAKE |=> reverse_phase_q != reverse_polarity_q
    && drive_level_q == peak_pos)
    else $error("brake not in reverse");
  // A level change under overdrive opens a burst while drive goes on
  a_boost_start: assert property (level_change ##1 state_q == ST_DRIVE |=> overdrive_active_q)
    else $error("no overdrive burst on level change");

  // Mode changes and rest states
  a_mode_zero: assert property (at_rest && mode_off |=> state_q == ST_INACTIVE)
    else $error("mode 0 did not go inactive");
  a_warm_return: assert property (state_q == ST_DRIVE && seq_stop && !brake_ok && !mode_off
    |=> state_q == $past(rest_state))
    else $error("wrong rest state");
  // Register-started mode waits for the start command
  a_reg_start: assert property (at_rest && playback_mode == MODE_REG_SEQ && !start_rise
    |=> state_q != ST_DRIVE)
    else $error("sequence started without command");

  // Wideband flag and retune pulse
  a_wideband_flag: assert property (booted |=> wideband_q == $past(wideband_ok))
    else $error("wideband flag wrong");
  a_retune: assert property (state_q == ST_DRIVE && period_we && wideband_ok
    && playback_mode == MODE_OVERRIDE |=> freq_update_q ##1 !freq_update_q || period_we)
    else $error("no retune on period write");

  // Main scenarios reached
  c_boot_done: cover property (state_q == ST_BOOT ##1 state_q == ST_INACTIVE);
  c_seq_play: cover property (state_q == ST_DRIVE && playback_mode == MODE_REG_SEQ ##1 state_q == ST_STANDBY);
  c_brake: cover property (state_q == ST_BRAKE ##1 state_q == ST_IDLE);
  c_edge_play: cover property (at_rest && playback_mode == MODE_EDGE_SEQ ##1 state_q == ST_DRIVE);
  c_boost: cover property (state_q == ST_DRIVE ##1 overdrive_active_q);
endmodule

// *** logic/haptic_pkg.sv ***
/*
  Constants, codes and types shared by the haptic drive setup and control logic.
  Assumes a single 250 MHz system clock and a host that drives the setup ports.
*/
package haptic_pkg;
  // -------------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------------
  localparam int CLK_MHZ      = 250;                 // System clock rate
  localparam int BOOT_TIME_NS = 1_500_000;           // Boot interval, 1.5 ms
  localparam int BOOT_CYCLES  = (BOOT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int BOOST_CYCLES = 32;                  // Overdrive burst length
  localparam int BRAKE_CYCLES = 64;                  // Reverse brake length
  // -------------------------------------------------------------------------
  // Field sizes and scalings
  // -------------------------------------------------------------------------
  localparam int        PER_LOW_W      = 7;          // Low part of period
  localparam int        PER_W          = 15;         // Full period width
  localparam longint    PER_UNIT_PS    = 1_333_320;  // Period unit in ps, 1333.32 ns
  localparam longint    SENSE_MAX_HZ   = 300;        // Fastest sensing rate
  // One second in ps over the fastest rate and the unit
  localparam logic [14:0] MIN_SENSE_PER =
    15'(64'd1_000_000_000_000 / (SENSE_MAX_HZ * PER_UNIT_PS));
  localparam logic [7:0] STORE_BASE    = 8'h00;      // First snippet location
  // -------------------------------------------------------------------------
  // Codes
  // -------------------------------------------------------------------------
  localparam logic [2:0] MODE_INACTIVE = 3'h0;
  localparam logic [2:0] MODE_OVERRIDE = 3'h1;       // Register override
  localparam logic [2:0] MODE_PWM      = 3'h2;
  localparam logic [2:0] MODE_REG_SEQ  = 3'h3;       // Register started
  localparam logic [2:0] MODE_EDGE_SEQ = 3'h4;       // Edge started
  localparam logic       KIND_LRA      = 1'b0;
  localparam logic       KIND_ERM      = 1'b1;

  typedef enum logic [2:0] {ST_BOOT, ST_INACTIVE, ST_IDLE, ST_STANDBY, ST_DRIVE, ST_BRAKE} play_state_t;
endpackage

// *** logic/store_if.sv ***
/*
  Carrier between the control core and the pattern store.
  Assumes both ends share clk_sys.
*/
`timescale 1ns/1ps
interface store_if;
  logic       we;     // Write strobe
  logic [7:0] addr;   // Byte location
  logic [7:0] wdata;  // Write data
  logic [7:0] rdata;  // Read data, registered
  logic       drop;   // Write refused, one cycle
  modport core  (output we, addr, wdata, input rdata, drop);
  modport store (input we, addr, wdata, output rdata, drop);
endinterface

// *** logic/pin_sync.sv ***
/*
  Two-stage synchroniser for one asynchronous pin.
  Assumes the pin is a level with no relation to clk_sys.
*/
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Pin and result
  input  wire logic pin,
  output logic      pin_s
);
  logic meta_q;  // First stage, read only by second

  // Two flops in series
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      pin_s  <= 1'b0;
    end else begin
      meta_q <= pin;
      pin_s  <= meta_q;
    end
  end
endmodule

// *** logic/pattern_store.sv ***
/*
  Pattern store: byte array with unlock gating.
  Assumes writes come from the control core on clk_sys.
*/
`timescale 1ns/1ps
module pattern_store
  import haptic_pkg::*;
#(
  parameter int DEPTH = 256
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Gating
  input  wire logic unlock,
  input  wire logic ready,
  // Access
  store_if.store    bus
);
  logic [7:0] mem [DEPTH];   // Contents, never reset
  wire        take = bus.we && unlock && ready;

  // Array write, no reset so contents persist
  always_ff @(posedge clk_sys) begin
    if (take) begin
      mem[bus.addr] <= bus.wdata;
    end
  end

  // Registered read and refusal flag
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus.rdata <= 8'h00;
      bus.drop  <= 1'b0;
    end else begin
      bus.rdata <= mem[bus.addr];
      bus.drop  <= bus.we && !take;
    end
  end

  a_store_locked: assert property (@(posedge clk_sys) disable iff (rst)
    bus.we && !unlock |=> bus.drop && mem[$past(bus.addr)] == $past(mem[bus.addr]))
    else $error("locked store took a write");
endmodule

// *** test/host_store_model.sv ***
/*
  Host model for pattern store uploads: unlock, write four bytes, relock.
  Assumes the device reports its state and store base on plain ports.
*/
`timescale 1ns/1ps
module host_store_model
  import haptic_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Commands from the bench
  input  wire logic        go,
  input  wire logic        skip_unlock,
  input  wire logic [7:0]  key,
  input  wire logic [7:0]  rd_addr,
  // Device status
  input  wire play_state_t state_q,
  input  wire logic [7:0]  base,
  // Store write port
  output logic             unlock,
  output logic             we,
  output logic [7:0]       addr,
  output logic [7:0]       wdata
);
  logic [1:0] n_q;     // Bytes written so far
  logic       busy_q;  // Upload running

  // Upload only from a quiet, booted device; relock after the last byte
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      n_q    <= 2'h0;
      unlock <= 1'b0;
    end else if (go && !busy_q && state_q == ST_INACTIVE) begin
      busy_q <= 1'b1;
      n_q    <= 2'h0;
      unlock <= !skip_unlock;
    end else if (busy_q) begin
      n_q <= n_q + 2'h1;
      if (n_q == 2'h3) begin
        busy_q <= 1'b0;
        unlock <= 1'b0;
      end
    end
  end

  // Writes start at the reported base, reads pass through when idle
  assign we    = busy_q;
  assign addr  = busy_q ? base + 8'(n_q) : rd_addr;
  assign wdata = addr ^ key;
endmodule

// *** test/tb_haptic_drive_setup_control.sv ***
/*
  Self-checking bench for the haptic setup and playback control block.
  Assumes a short boot parameter; trigger pin idles low.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("FAIL t=%0t got %0h exp %0h", $time, a, e); end end
module tb_haptic_drive_setup_control;
  import haptic_pkg::*;
  localparam int BOOT        = 20;    // Shortened boot
  localparam int SENSE_FLOOR = 2500;  // 300 Hz in 1333.32 ns units
  logic clk_sys, rst, kind, per_we, trk, od, brk, warm, start, sdone, pin, go, skip;
  logic [7:0] rated, peak, sh, sl, ph, amp, rd_addr, key;
  logic [6:0] pl;
  logic [4:0] ilim, cl;
  logic [2:0] mode;
  logic unlock, we, dropped, lra, erm, odact, rph, rpol, wb, fu, fault;
  logic [7:0] addr, wdata, rdata, base, nom;
  logic [15:0] scl;
  logic [14:0] per, sper;
  logic signed [8:0] lvl;
  play_state_t st;
  int num_errors, checks;

  haptic_drive_setup_control #(.BOOT_LEN(BOOT), .STORE_DEPTH(256)) dut (
    .clk_sys(clk_sys), .rst(rst), .actuator_kind(kind), .rated_voltage_code(rated),
    .peak_limit_code(peak), .current_limit_code(ilim), .scale_high_byte(sh), .scale_low_byte(sl),
    .resonance_period_high(ph), .resonance_period_low(pl), .period_we(per_we), .tracking_en(trk),
    .overdrive_en(od), .reverse_brake_en(brk), .warm_wait_en(warm), .playback_mode(mode),
    .seq_start(start), .seq_done(sdone), .trigger_pin(pin), .amp_in(amp),
    .pattern_store_unlock(unlock), .store_we(we), .store_addr(addr), .store_wdata(wdata),
    .store_rdata(rdata), .store_dropped(dropped), .pattern_store_base_q(base), .state_q(st),
    .drive_lra_q(lra), .drive_erm_q(erm), .nominal_level_q(nom), .current_limit_q(cl),
    .voltage_to_current_scale_q(scl), .resonance_period_q(per), .sense_period_q(sper),
    .drive_level_q(lvl), .overdrive_active_q(odact), .reverse_phase_q(rph),
    .reverse_polarity_q(rpol), .wideband_q(wb), .freq_update_q(fu), .feature_fault_q(fault));

  host_store_model host (.clk_sys(clk_sys), .rst(rst), .go(go), .skip_unlock(skip), .key(key),
    .rd_addr(rd_addr), .state_q(st), .base(base), .unlock(unlock), .we(we), .addr(addr),
    .wdata(wdata));

  // Clock, 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic settle(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Bounded wait for a state, then compare
  task automatic wait_st(play_state_t s, int lim);
    for (int i = 0; i < lim && st !== s; i++) settle(1);
    `CHK(st, s)
  endtask

  // Store read, one cycle latency after the address
  task automatic rd(logic [7:0] a, logic [7:0] e);
    rd_addr <= a;
    settle(2);
    `CHK(rdata, e)
  endtask

  task automatic period(logic [7:0] h, logic [6:0] l);
    ph <= h;
    pl <= l;
    per_we <= 1'b1;
    settle(1);
    per_we <= 1'b0;
    settle(1);
  endtask

  task automatic wrap_up;
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial begin
    #20000;
    num_errors++;
    wrap_up();
  end

  initial begin
    {kind, per_we, trk, od, brk, warm, start, sdone, pin, go, skip} = '0;
    {sh, sl, ph, amp, rd_addr, key, pl, ilim, mode} = '0;
    rated = 8'h50;
    peak = 8'h64;
    rst = 1'b1;
    settle(2);
    rst <= 1'b0;
    settle(BOOT - 2);
    `CHK(st, ST_BOOT)
    wait_st(ST_INACTIVE, 10);
    // Actuator setup, rotating mass first
    kind <= 1'b1;
    ilim <= 5'h13;
    sh <= 8'h12;
    sl <= 8'h34;
    settle(1);
    period(8'h01, 7'h05);
    `CHK(erm, 1'b1)
    `CHK(lra, 1'b0)
    `CHK(nom, 8'h50)
    `CHK(cl, 5'h13)
    `CHK(scl, 16'h1234)
    `CHK(per, 15'd133)
    `CHK(sper, 15'(SENSE_FLOOR))
    period(8'hFF, 7'h7F);
    `CHK(per, 15'h7FFF)
    `CHK(sper, 15'h7FFF)
    kind <= 1'b0;
    mode <= MODE_REG_SEQ;
    settle(4);
    `CHK(lra, 1'b1)
    `CHK(st, ST_INACTIVE)
    // Sequence start and finish, both rest states
    for (int w = 0; w < 2; w++) begin
      warm <= w[0];
      start <= 1'b1;
      settle(2);
      `CHK(st, ST_DRIVE)
      sdone <= 1'b1;
      settle(2);
      sdone <= 1'b0;
      start <= 1'b0;
      `CHK(st, w[0] ? ST_STANDBY : ST_IDLE)
      settle(2);
    end
    // Edge-started playback from the trigger pin, frequency set first
    period(8'h01, 7'h05);
    mode <= MODE_EDGE_SEQ;
    pin <= 1'b1;
    settle(3);
    `CHK(st, ST_DRIVE)
    pin <= 1'b0;
    settle(3);
    `CHK(st, ST_STANDBY)
    mode <= MODE_INACTIVE;
    settle(2);
    `CHK(st, ST_INACTIVE)
    // Amplitude reading and overdrive burst
    mode <= MODE_OVERRIDE;
    amp <= 8'hF0;
    settle(4);
    `CHK(lvl, 9'sd100)
    trk <= 1'b1;
    od <= 1'b1;
    settle(3);
    `CHK(odact, 1'b1)
    `CHK(lvl, -9'sd100)
    settle(40);
    `CHK(lvl, -9'sd16)
    `CHK(odact, 1'b0)
    trk <= 1'b0;
    settle(2);
    `CHK(fault, 1'b1)
    trk <= 1'b1;
    settle(2);
    `CHK(fault, 1'b0)
    // Reverse brake on both actuator kinds
    brk <= 1'b1;
    od <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      mode <= k ? MODE_PWM : MODE_OVERRIDE;
      settle(3);
      mode <= MODE_INACTIVE;
      settle(3);
      `CHK(st, ST_BRAKE)
      `CHK(k ? rpol : rph, 1'b1)
      wait_st(ST_INACTIVE, 80);
      kind <= 1'b1;
    end
    // Wideband retune in override streaming
    {brk, trk, od, kind} <= '0;
    mode <= MODE_OVERRIDE;
    settle(3);
    `CHK(wb, 1'b1)
    per_we <= 1'b1;
    settle(1);
    per_we <= 1'b0;
    `CHK(fu, 1'b1)
    settle(1);
    `CHK(fu, 1'b0)
    mode <= MODE_INACTIVE;
    settle(3);
    // Store upload, locked attempt, reset retention
    `CHK(base, 8'h00)
    key <= 8'hA5;
    go <= 1'b1;
    settle(1);
    go <= 1'b0;
    settle(8);
    for (int i = 0; i < 4; i++) rd(8'(i), 8'(i) ^ 8'hA5);
    skip <= 1'b1;
    key <= 8'h3C;
    go <= 1'b1;
    settle(1);
    go <= 1'b0;
    settle(1);
    `CHK(dropped, 1'b1)
    settle(6);
    for (int i = 0; i < 4; i++) rd(8'(i), 8'(i) ^ 8'hA5);
    rst <= 1'b1;
    settle(2);
    rst <= 1'b0;
    wait_st(ST_INACTIVE, BOOT + 5);
    for (int i = 0; i < 4; i++) rd(8'(i), 8'(i) ^ 8'hA5);
    wrap_up();
  end
endmodule
